// [design/flash_host_defines.vh]
/*
  Constants shared by the flash host controller: command bytes, register
  word indices, field positions, operation codes and bus cycle timing.
  Assumes a 40 MHz system clock and an x16 flash with 19 word-address bits.
*/
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// ==========================================================================
// Device command bytes
`define CMD_READ_ARRAY    8'hff
`define CMD_PROG_SETUP    8'h40
`define CMD_PROG_SETUP_ALT 8'h10
`define CMD_ERASE_SETUP   8'h20
`define CMD_CONFIRM       8'hd0
`define CMD_SUSPEND       8'hb0
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50

// ==========================================================================
// Device status bits
`define SR_READY_BIT      7
`define SR_SUSPENDED_BIT  6

// ==========================================================================
// Register word indices on the Avalon slave
`define REG_CTRL          3'h0
`define REG_CMD           3'h1
`define REG_ADDR          3'h2
`define REG_WDATA         3'h3
`define REG_STATUS        3'h4
`define REG_RDATA         3'h5

`define CTRL_POWERDOWN    0
`define CTRL_ALT_SETUP    1
`define ST_BUSY           8
`define ST_ERASING        9
`define ST_SUSPENDED      10
`define ST_ARRAY_MODE     11
`define ST_REFUSED        12

// ==========================================================================
// Operation codes written to the command register
`define OP_READ_ARRAY     4'h1
`define OP_READ_STATUS    4'h2
`define OP_CLEAR_STATUS   4'h3
`define OP_PROGRAM        4'h4
`define OP_ERASE          4'h5
`define OP_SUSPEND        4'h6
`define OP_RESUME         4'h7
`define OP_ABORT_PROGRAM  4'h8
`define OP_ABORT_ERASE    4'h9
`define OP_ARRAY_READ     4'ha

// ==========================================================================
// Bus cycle timing
`define CLK_PERIOD_NS     25
`define T_SETUP_NS        25
`define T_STROBE_NS       100
`define T_HOLD_NS         25
`define SETUP_CYC  ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC   ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [design/flash_bus_cycle.v]
/*
  One asynchronous SRAM-style bus cycle (write or read) on the flash pins.
  Assumes the caller pulses i_start only while o_busy is low and holds the
  reset/power-down pin itself.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"

module flash_bus_cycle (
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire        i_abort,
  input  wire        i_start,
  input  wire        i_write,
  input  wire [18:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire [15:0] i_dq_in,
  output reg         o_busy,
  output reg         o_done,
  output reg  [15:0] o_rdata,
  output reg         o_ce_n,
  output reg         o_oe_n,
  output reg         o_we_n,
  output reg  [18:0] o_addr,
  output reg  [15:0] o_dq_out,
  output reg         o_dq_oe
);

  // ========================================================================
  // Phase machine
  localparam [3:0] P_IDLE   = 4'h1;
  localparam [3:0] P_SETUP  = 4'h2;
  localparam [3:0] P_STROBE = 4'h4;
  localparam [3:0] P_HOLD   = 4'h8;
  localparam integer SETUP_W  = `SETUP_CYC;
  localparam integer STROBE_W = `STROBE_CYC;
  localparam integer HOLD_W   = `HOLD_CYC;
  localparam [3:0] SETUP_N  = SETUP_W[3:0];
  localparam [3:0] STROBE_N = STROBE_W[3:0];
  localparam [3:0] HOLD_N   = HOLD_W[3:0];

  reg [3:0] phase_q;
  reg [3:0] cnt_q;
  reg       write_q;

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_q  <= P_IDLE;
      cnt_q    <= 4'h0;
      write_q  <= 1'b0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
      o_rdata  <= 16'h0000;
      o_ce_n   <= 1'b1;
      o_oe_n   <= 1'b1;
      o_we_n   <= 1'b1;
      o_addr   <= 19'h00000;
      o_dq_out <= 16'h0000;
      o_dq_oe  <= 1'b0;
    end else if (i_abort) begin
      phase_q <= P_IDLE;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
      o_dq_oe <= 1'b0;
    end else begin
      o_done <= 1'b0;
      cnt_q  <= cnt_q + 4'h1;
      case (phase_q)
        P_IDLE: begin
          if (i_start) begin
            phase_q  <= P_SETUP;
            cnt_q    <= 4'h1;
            write_q  <= i_write;
            o_busy   <= 1'b1;
            o_addr   <= i_addr;
            o_dq_out <= i_wdata;
            o_dq_oe  <= i_write;
            o_ce_n   <= 1'b0;
          end
        end
        P_SETUP: begin
          if (cnt_q >= SETUP_N) begin
            phase_q <= P_STROBE;
            cnt_q   <= 4'h1;
            o_we_n  <= ~write_q;
            o_oe_n  <= write_q;
          end
        end
        P_STROBE: begin
          if (cnt_q >= STROBE_N) begin
            // Each read ends with OE and CE high, so the next read fetches a fresh status.
            phase_q <= P_HOLD;
            cnt_q   <= 4'h1;
            o_we_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            o_ce_n  <= 1'b1;
            if (!write_q) begin
              o_rdata <= i_dq_in;
            end
          end
        end
        P_HOLD: begin
          if (cnt_q >= HOLD_N) begin
            phase_q <= P_IDLE;
            o_dq_oe <= 1'b0;
            o_busy  <= 1'b0;
            o_done  <= 1'b1;
          end
        end
        default: begin
          phase_q <= P_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle

`default_nettype wire

// [design/flash_host_ctrl.v]
/*
  Host-side controller for a boot-block flash command decoder. Software
  posts operations over Avalon-MM; the controller turns them into command
  bus cycles, polls the device status and tracks the device's read mode.
  Assumes the flash pins are wired directly and the data bus is resolved
  outside from o_flash_dq_oe.
*/
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
// Behaviour
// - Never write the reserved command byte 00h to the device.
// - Cancel a pending erase with erase set-up then one read-array.
// - Cancel a pending program with program set-up then two read-arrays.
// - After programming, issue read-array before reading array data.
// - Failure flags only set by the device; host clears with 50h.
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"

module flash_host_ctrl (
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire [2:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire [15:0] i_flash_dq_in,
  output wire [15:0] o_flash_dq_out,
  output wire        o_flash_dq_oe,
  output wire [18:0] o_flash_addr,
  output wire        o_flash_ce_n,
  output wire        o_flash_oe_n,
  output wire        o_flash_we_n,
  output reg         o_flash_rp_n
);

  // ========================================================================
  // Sequencer states
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_STEP = 3'h2;
  localparam [2:0] S_WAIT = 3'h4;
  localparam [1:0] FIN_NONE   = 2'h0;
  localparam [1:0] FIN_ARRAY  = 2'h1;
  localparam [1:0] FIN_STATUS = 2'h2;

  reg  [2:0]  state_q;
  reg  [3:0]  op_q;
  reg  [1:0]  n_steps_q;
  reg  [1:0]  idx_q;
  reg  [15:0] st0_q;
  reg  [15:0] st1_q;
  reg  [15:0] st2_q;
  reg  [1:0]  fin_q;
  reg         poll_q;
  reg         cur_read_q;
  reg         cyc_start_q;
  reg         cyc_write_q;
  reg  [15:0] cyc_data_q;
  reg  [1:0]  ctrl_q;
  reg  [18:0] addr_q;
  reg  [15:0] wdata_q;
  reg  [7:0]  dev_status_q;
  reg  [15:0] rdata_q;
  reg         erasing_q;
  reg         suspended_q;
  reg         array_mode_q;
  reg         refused_q;
  wire        cyc_done;
  wire [15:0] cyc_rdata;

  wire busy      = (state_q != S_IDLE);
  wire wr_cmd    = i_avs_write && (i_avs_address == `REG_CMD);
  wire hold_req  = busy && i_avs_write && (i_avs_address != `REG_CTRL)
                   && (i_avs_address != `REG_STATUS);
  wire take_wr   = i_avs_write && !o_avs_waitrequest;
  wire clr_refused = take_wr && (i_avs_address == `REG_STATUS) && i_avs_writedata[`ST_REFUSED];
  wire [3:0] new_op = i_avs_writedata[3:0];
  wire pd        = ctrl_q[`CTRL_POWERDOWN];
  wire [15:0] setup_cmd = ctrl_q[`CTRL_ALT_SETUP] ? {8'h00, `CMD_PROG_SETUP_ALT}
                                                  : {8'h00, `CMD_PROG_SETUP};

  // Host restraint: while erasing or suspended only the accepted commands go out.
  reg op_ok;
  always @* begin
    op_ok = 1'b0;
    if (pd) begin
      op_ok = 1'b0;
    end else if (erasing_q && !suspended_q) begin
      op_ok = (new_op == `OP_READ_STATUS) || (new_op == `OP_SUSPEND);
    end else if (suspended_q) begin
      op_ok = (new_op == `OP_READ_ARRAY) || (new_op == `OP_READ_STATUS)
              || (new_op == `OP_RESUME) || (new_op == `OP_ARRAY_READ);
    end else begin
      op_ok = (new_op >= `OP_READ_ARRAY) && (new_op <= `OP_ARRAY_READ)
              && (new_op != `OP_SUSPEND) && (new_op != `OP_RESUME);
    end
  end

  // ========================================================================
  // Avalon-MM slave
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
      ctrl_q            <= 2'h0;
      addr_q            <= 19'h00000;
      wdata_q           <= 16'h0000;
    end else begin
      o_avs_waitrequest <= 1'b1;
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest && !hold_req) begin
        o_avs_waitrequest <= 1'b0;
        case (i_avs_address)
          `REG_CTRL:   o_avs_readdata <= {30'h0, ctrl_q};
          `REG_CMD:    o_avs_readdata <= {28'h0, op_q};
          `REG_ADDR:   o_avs_readdata <= {13'h0, addr_q};
          `REG_WDATA:  o_avs_readdata <= {16'h0, wdata_q};
          `REG_STATUS: o_avs_readdata <= {19'h0, refused_q, array_mode_q, suspended_q,
                                          erasing_q, busy, dev_status_q};
          `REG_RDATA:  o_avs_readdata <= {16'h0, rdata_q};
          default:     o_avs_readdata <= 32'h00000000;
        endcase
      end
      if (take_wr && (i_avs_address == `REG_CTRL)) begin
        ctrl_q <= i_avs_writedata[1:0];
      end
      if (take_wr && (i_avs_address == `REG_ADDR)) begin
        addr_q <= i_avs_writedata[18:0];
      end
      if (take_wr && (i_avs_address == `REG_WDATA)) begin
        wdata_q <= i_avs_writedata[15:0];
      end
    end
  end

  // ========================================================================
  // Reset/power-down pin
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flash_rp_n <= 1'b0;
    end else begin
      o_flash_rp_n <= ~pd;
    end
  end

  // ========================================================================
  // Operation sequencer and device mode tracking
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q      <= S_IDLE;
      op_q         <= 4'h0;
      n_steps_q    <= 2'h0;
      idx_q        <= 2'h0;
      st0_q        <= 16'h0000;
      st1_q        <= 16'h0000;
      st2_q        <= 16'h0000;
      fin_q        <= FIN_NONE;
      poll_q       <= 1'b0;
      cur_read_q   <= 1'b0;
      cyc_start_q  <= 1'b0;
      cyc_write_q  <= 1'b0;
      cyc_data_q   <= 16'h0000;
      dev_status_q <= 8'h00;
      rdata_q      <= 16'h0000;
      erasing_q    <= 1'b0;
      suspended_q  <= 1'b0;
      array_mode_q <= 1'b1;
      refused_q    <= 1'b0;
    end else if (pd) begin
      // Power-down wipes the device state, so the model restarts in array mode.
      state_q      <= S_IDLE;
      cyc_start_q  <= 1'b0;
      erasing_q    <= 1'b0;
      suspended_q  <= 1'b0;
      array_mode_q <= 1'b1;
      // Software may still clear the refusal while the device is powered down.
      if (wr_cmd && take_wr) begin
        refused_q <= 1'b1;
      end else if (clr_refused) begin
        refused_q <= 1'b0;
      end
    end else begin
      cyc_start_q <= 1'b0;
      // A refusal in the same cycle as its clear still sticks.
      if (clr_refused) begin
        refused_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (wr_cmd && take_wr) begin
            if (!op_ok) begin
              refused_q <= 1'b1;
            end else begin
              op_q    <= new_op;
              idx_q   <= 2'h0;
              fin_q   <= FIN_NONE;
              poll_q  <= 1'b0;
              state_q <= S_STEP;
              st0_q   <= {8'h00, `CMD_READ_ARRAY};
              st1_q   <= {8'h00, `CMD_READ_ARRAY};
              st2_q   <= {8'h00, `CMD_READ_ARRAY};
              case (new_op)
                `OP_READ_ARRAY: begin
                  n_steps_q <= 2'h1;
                end
                `OP_READ_STATUS: begin
                  n_steps_q <= 2'h1;
                  st0_q     <= {8'h00, `CMD_READ_STATUS};
                  fin_q     <= FIN_STATUS;
                end
                `OP_CLEAR_STATUS: begin
                  n_steps_q <= 2'h1;
                  st0_q     <= {8'h00, `CMD_CLEAR_STATUS};
                end
                `OP_PROGRAM: begin
                  n_steps_q <= 2'h2;
                  st0_q     <= setup_cmd;
                  st1_q     <= wdata_q;
                  poll_q    <= 1'b1;
                end
                `OP_ERASE: begin
                  n_steps_q <= 2'h2;
                  st0_q     <= {8'h00, `CMD_ERASE_SETUP};
                  st1_q     <= {8'h00, `CMD_CONFIRM};
                end
                `OP_SUSPEND: begin
                  n_steps_q <= 2'h1;
                  st0_q     <= {8'h00, `CMD_SUSPEND};
                  poll_q    <= 1'b1;
                end
                `OP_RESUME: begin
                  n_steps_q <= 2'h1;
                  st0_q     <= {8'h00, `CMD_CONFIRM};
                end
                `OP_ABORT_PROGRAM: begin
                  n_steps_q <= 2'h3;
                  st0_q     <= setup_cmd;
                end
                `OP_ABORT_ERASE: begin
                  n_steps_q <= 2'h2;
                  st0_q     <= {8'h00, `CMD_ERASE_SETUP};
                end
                default: begin
                  // Array read: restore array mode first when the device is elsewhere.
                  n_steps_q <= array_mode_q ? 2'h0 : 2'h1;
                  fin_q     <= FIN_ARRAY;
                end
              endcase
            end
          end
        end
        S_STEP: begin
          cyc_start_q <= 1'b1;
          state_q     <= S_WAIT;
          if (idx_q < n_steps_q) begin
            cur_read_q  <= 1'b0;
            cyc_write_q <= 1'b1;
            cyc_data_q  <= (idx_q == 2'h0) ? st0_q : ((idx_q == 2'h1) ? st1_q : st2_q);
          end else if ((fin_q != FIN_NONE) || poll_q) begin
            cur_read_q  <= 1'b1;
            cyc_write_q <= 1'b0;
          end else begin
            cyc_start_q <= 1'b0;
            state_q     <= S_IDLE;
            case (op_q)
              `OP_READ_ARRAY, `OP_ABORT_PROGRAM, `OP_ABORT_ERASE: begin
                array_mode_q <= 1'b1;
              end
              `OP_ERASE: begin
                erasing_q    <= 1'b1;
                array_mode_q <= 1'b0;
              end
              `OP_RESUME: begin
                suspended_q  <= 1'b0;
                array_mode_q <= 1'b0;
              end
              default: begin
                array_mode_q <= 1'b0;
              end
            endcase
          end
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (!cur_read_q) begin
              idx_q   <= idx_q + 2'h1;
              state_q <= S_STEP;
            end else if (fin_q == FIN_ARRAY) begin
              rdata_q      <= cyc_rdata;
              array_mode_q <= 1'b1;
              state_q      <= S_IDLE;
            end else begin
              dev_status_q <= cyc_rdata[7:0];
              array_mode_q <= 1'b0;
              if (cyc_rdata[`SR_READY_BIT]) begin
                // Ready with the suspended flag means suspend reached, else erase ended.
                state_q     <= S_IDLE;
                suspended_q <= erasing_q && cyc_rdata[`SR_SUSPENDED_BIT];
                erasing_q   <= erasing_q && cyc_rdata[`SR_SUSPENDED_BIT];
              end else if (poll_q) begin
                state_q <= S_STEP;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Pin cycle engine
  flash_bus_cycle u_cycle (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_abort   (pd),
    .i_start   (cyc_start_q),
    .i_write   (cyc_write_q),
    .i_addr    (addr_q),
    .i_wdata   (cyc_data_q),
    .i_dq_in   (i_flash_dq_in),
    .o_busy    (),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .o_ce_n    (o_flash_ce_n),
    .o_oe_n    (o_flash_oe_n),
    .o_we_n    (o_flash_we_n),
    .o_addr    (o_flash_addr),
    .o_dq_out  (o_flash_dq_out),
    .o_dq_oe   (o_flash_dq_oe)
  );

endmodule // flash_host_ctrl

`default_nettype wire

// [testbench/flash_host_ctrl_assertions.sv]
/* Concurrent checks on the flash host controller's ports.
   Assumes the bind below reaches the single top instance. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Port checker
module flash_host_ctrl_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic [15:0] o_flash_dq_out,
  input wire logic        o_flash_dq_oe,
  input wire logic [18:0] o_flash_addr,
  input wire logic        o_flash_ce_n,
  input wire logic        o_flash_oe_n,
  input wire logic        o_flash_we_n,
  input wire logic        o_flash_rp_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence we_pulse; !o_flash_we_n [*4] ##1 o_flash_we_n; endsequence
  sequence oe_pulse; !o_flash_oe_n [*4] ##1 o_flash_oe_n; endsequence
  ack_single_a: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  ack_needs_req_a: assert property (!o_avs_waitrequest |-> i_avs_read || i_avs_write)
    else $error("waitrequest low without a request");
  pd_quiet_a: assert property (!o_flash_rp_n && !$past(o_flash_rp_n)
    |-> o_flash_ce_n && o_flash_we_n && o_flash_oe_n) else $error("strobe in power-down");
  no_reserved_a: assert property ($fell(o_flash_we_n) |-> o_flash_dq_out != 16'h0000)
    else $error("reserved command byte written");
  write_pulse_a: assert property ($fell(o_flash_we_n) |-> we_pulse)
    else $error("write strobe width wrong");
  read_pulse_a: assert property ($fell(o_flash_oe_n) |-> oe_pulse)
    else $error("read strobe width wrong");
  write_setup_a: assert property ($fell(o_flash_we_n) |-> !$past(o_flash_ce_n) && o_flash_dq_oe)
    else $error("write strobe without chip enable or data");
  read_quiet_a: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && o_flash_we_n && !o_flash_ce_n)
    else $error("data driven during a read");
  write_hold_a: assert property (!o_flash_we_n |-> $stable(o_flash_dq_out) && $stable(o_flash_addr))
    else $error("address or data moved under write strobe");
endmodule // flash_host_ctrl_checker
bind flash_host_ctrl flash_host_ctrl_checker chk (.i_sys_clk, .i_resetn, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .o_flash_dq_out, .o_flash_dq_oe, .o_flash_addr, .o_flash_ce_n,
  .o_flash_oe_n, .o_flash_we_n, .o_flash_rp_n);
`default_nettype wire

// [testbench/flash_dev_model.sv]
/* Behavioural flash device with its command decoder and a 16-word array.
   Assumes the host strobes; busy time counts reads, not time. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Device model
module flash_dev_model #(parameter int BUSY_READS = 3) (
  input  wire logic        rp_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  output wire logic [15:0] dq_in
);
  localparam int IDLE = 0, PSET = 1, PABT = 2, ESET = 3, PROG = 4, ERAS = 5, SUSP = 6;
  int          step, cnt;
  logic        st_mode, sel;
  logic [1:0]  fail;
  logic [15:0] mem [0:15];
  logic [15:0] dout;
  wire  [7:0]  c  = dq_out[7:0];
  wire  [7:0]  sr = {step != PROG && step != ERAS, step == SUSP, fail, 4'h0};
  // A released bus shows the inverse of the last value, never a stale copy.
  assign dq_in = dq_oe ? dq_out : (!ce_n && !oe_n && rp_n) ? dout : ~dout;
  initial begin
    step = IDLE; cnt = 0; st_mode = 0; sel = 0; fail = 0; dout = 0;
    for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 + i;
  end
  always @(negedge rp_n) begin step = IDLE; st_mode = 0; end
  // Chip enable rises with the write strobe, so it is judged at the falling edge.
  always @(negedge we_n) sel = !ce_n && rp_n;
  always @(posedge we_n) if (sel && rp_n) begin
    case (step)
      PSET, PABT: if (c == 8'hff && step == PSET) step = PABT;
        else if (c == 8'hff) begin step = IDLE; st_mode = 0; end
        else begin mem[addr[3:0]] = dq_out; step = PROG; cnt = BUSY_READS; end
      ESET: if (c == 8'hd0) begin step = ERAS; cnt = 2 * BUSY_READS; end
        else if (c == 8'hff) begin step = IDLE; st_mode = 0; end
        else begin fail = 2'b11; step = IDLE; st_mode = 1; end
      ERAS: if (c == 8'hb0) step = SUSP; else if (c == 8'h70) st_mode = 1;
      SUSP: if (c == 8'hff) st_mode = 0; else if (c == 8'h70) st_mode = 1;
        else if (c == 8'hd0) begin step = ERAS; st_mode = 1; end
      PROG: ;
      default: case (c)
        8'hff: st_mode = 0;
        8'h40, 8'h10: begin step = PSET; st_mode = 1; end
        8'h20: step = ESET;
        8'h70: st_mode = 1;
        8'h50: fail = 2'b00;
        default: ;
      endcase
    endcase
  end
  always @(negedge oe_n or negedge ce_n) if (!ce_n && !oe_n && rp_n) begin
    if ((step == PROG || step == ERAS) && cnt > 0) cnt--;
    if ((step == PROG || step == ERAS) && cnt == 0) begin
      if (step == ERAS) for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
      step = IDLE; st_mode = 1;
    end
    dout = st_mode ? {8'h00, sr} : mem[addr[3:0]];
  end
endmodule // flash_dev_model
`default_nettype wire

// [testbench/tb.sv]
/* Self-checking bench for the flash host controller.
   Assumes the device model is the only party on the flash pins. */
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defines.vh"
// ==========================================================================
// Bench
module tb;
  logic        i_sys_clk = 0, i_resetn = 0, i_avs_read = 0, i_avs_write = 0;
  logic [2:0]  i_avs_address = 0;
  logic [31:0] i_avs_writedata = 0;
  wire  [31:0] o_avs_readdata;
  wire         o_avs_waitrequest, o_flash_dq_oe, o_flash_ce_n, o_flash_oe_n, o_flash_we_n;
  wire         o_flash_rp_n;
  wire  [15:0] i_flash_dq_in, o_flash_dq_out;
  wire  [18:0] o_flash_addr;
  int          bad_count = 0, checks = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  flash_host_ctrl uut (.i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_flash_dq_in, .o_flash_dq_out,
    .o_flash_dq_oe, .o_flash_addr, .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n, .o_flash_rp_n);
  flash_dev_model dev (.rp_n(o_flash_rp_n), .ce_n(o_flash_ce_n), .oe_n(o_flash_oe_n),
    .we_n(o_flash_we_n), .addr(o_flash_addr), .dq_out(o_flash_dq_out), .dq_oe(o_flash_dq_oe),
    .dq_in(i_flash_dq_in));
  task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_sys_clk);
    i_avs_address <= a; i_avs_writedata <= d; i_avs_write <= w; i_avs_read <= !w;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 0; i_avs_read <= 0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1, a, d, q);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reg_is(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    acc(0, a, 32'h0, q);
    chk($sformatf("reg %0d", a), e, q & m);
  endtask
  // Software waits on the busy flag; the watchdog bounds a device that never finishes.
  task automatic op(input logic [3:0] o);
    logic [31:0] q;
    wr(`REG_CMD, {28'h0, o});
    do acc(0, `REG_STATUS, 32'h0, q); while (q[`ST_BUSY] !== 1'b0);
  endtask
  task automatic array_is(input logic [18:0] a, input logic [15:0] e);
    wr(`REG_ADDR, {13'h0, a});
    op(`OP_ARRAY_READ);
    reg_is(`REG_RDATA, 32'hffff, {16'h0, e});
  endtask
  task automatic t_idle;
    reg_is(`REG_STATUS, 32'h1f00, 32'h0800);
    reg_is(3'h6, 32'hffffffff, 32'h0);
    reg_is(`REG_CTRL, 32'h3, 32'h0);
  endtask
  task automatic t_program;
    for (int k = 0; k < 2; k++) begin
      wr(`REG_CTRL, k << 1);
      wr(`REG_ADDR, 3 + k);
      wr(`REG_WDATA, 32'h1234 + k);
      op(`OP_PROGRAM);
      reg_is(`REG_STATUS, 32'h1fff, 32'h0080);
      array_is(3 + k, 16'h1234 + k);
      reg_is(`REG_STATUS, 32'h0800, 32'h0800);
    end
  endtask
  task automatic t_abort;
    for (int k = 0; k < 2; k++) begin
      wr(`REG_ADDR, 5 + k);
      op(k ? `OP_ABORT_ERASE : `OP_ABORT_PROGRAM);
      array_is(5 + k, 16'h5a05 + k);
      op(`OP_READ_STATUS);
      reg_is(`REG_STATUS, 32'h08ff, 32'h0080);
    end
  endtask
  task automatic t_erase;
    logic [31:0] q;
    wr(`REG_ADDR, 0);
    op(`OP_ERASE);
    reg_is(`REG_STATUS, 32'h1700, 32'h0200);
    op(`OP_ARRAY_READ);
    reg_is(`REG_STATUS, 32'h1200, 32'h1200);
    wr(`REG_STATUS, 32'h1000);
    op(`OP_SUSPEND);
    reg_is(`REG_STATUS, 32'h15ff, 32'h04c0);
    array_is(3, 16'h1234);
    op(`OP_RESUME);
    for (int i = 0; i < 10; i++) begin
      op(`OP_READ_STATUS);
      acc(0, `REG_STATUS, 32'h0, q);
      if (q[`ST_ERASING] === 1'b0) break;
    end
    chk("erase end status", 32'h0080, q & 32'h03ff);
    array_is(3, 16'hffff);
  endtask
  task automatic t_refuse;
    logic [3:0] bad [4] = '{`OP_SUSPEND, `OP_RESUME, 4'h0, 4'hf};
    foreach (bad[i]) begin
      op(bad[i]);
      reg_is(`REG_STATUS, 32'h1000, 32'h1000);
      wr(`REG_STATUS, 32'h1000);
    end
    op(`OP_CLEAR_STATUS);
    op(`OP_READ_STATUS);
    reg_is(`REG_STATUS, 32'h10ff, 32'h0080);
  endtask
  task automatic t_powerdown;
    wr(`REG_CTRL, 32'h1);
    op(`OP_READ_ARRAY);
    reg_is(`REG_STATUS, 32'h1000, 32'h1000);
    wr(`REG_STATUS, 32'h1000);
    wr(`REG_CTRL, 32'h0);
    reg_is(`REG_STATUS, 32'h1800, 32'h0800);
    array_is(4, 16'hffff);
  endtask
  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1;
    t_idle;
    t_program;
    t_abort;
    t_erase;
    t_refuse;
    t_powerdown;
    stop_test;
  end
endmodule // tb
`default_nettype wire
